// *** hw/fsr_read_states.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsr_read_states #(
	parameter int ADDR_W = 16,
	parameter int LOCK_W = 2
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	// Flash bus
	input  wire logic                chip_enable_n,
	input  wire logic                output_enable_n,
	input  wire logic                write_enable_n,
	input  wire logic                address_valid_n,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic [15:0]         data_in,
	output logic      [15:0]         data_out,
	output logic                     data_oe,
	// Read configuration
	input  wire logic                sync_burst_mode,
	input  wire logic [15:0]         read_configuration_word,
	// Array and lock state
	input  wire logic [15:0]         array_data,
	input  wire logic [LOCK_W-1:0]   block_lock_state,
	input  wire logic [15:0]         otp_lock_word_0,
	input  wire logic [15:0]         otp_lock_word_1,
	// Write engine
	input  wire fsr_pkg::fsr_engine_t engine,
	// Protection and query memory loading
	input  wire logic                prot_wr,
	input  wire logic [7:0]          prot_wr_idx,
	input  wire logic                cfi_wr,
	input  wire logic [5:0]          cfi_wr_idx,
	input  wire logic [15:0]         mem_wr_data,
	// Observation
	output fsr_pkg::fsr_mode_t       read_mode,
	output logic      [7:0]          status_word
);

	// ************************************************************
	// Bus edge detection
	// ************************************************************
	logic ce_q;
	logic oe_q;
	logic we_q;
	logic adv_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ce_q  <= 1'b1;
			oe_q  <= 1'b1;
			we_q  <= 1'b1;
			adv_q <= 1'b1;
		end else begin
			ce_q  <= chip_enable_n;
			oe_q  <= output_enable_n;
			we_q  <= write_enable_n;
			adv_q <= address_valid_n;
		end
	end

	logic ce_fall;
	logic oe_fall;
	logic adv_fall;
	logic wr_done;
	assign ce_fall  = ce_q && !chip_enable_n;
	assign oe_fall  = oe_q && !output_enable_n;
	assign adv_fall = adv_q && !address_valid_n;
	// Command taken at the rising edge of the write strobe
	assign wr_done  = !we_q && write_enable_n && !chip_enable_n;

	// ************************************************************
	// Command decode
	// ************************************************************
	logic [7:0] cmd;
	logic       operand_due;
	logic       clr_stat;
	assign cmd      = data_in[7:0];
	assign clr_stat = wr_done && !operand_due && cmd == fsr_pkg::CMD_CLR_STAT;

	// Second write of a setup sequence is data, never a command
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			operand_due <= 1'b0;
		end else if (wr_done) begin
			operand_due <= !operand_due && (cmd == fsr_pkg::CMD_PROG_A || cmd == fsr_pkg::CMD_PROG_B
				|| cmd == fsr_pkg::CMD_ERASE || cmd == fsr_pkg::CMD_LOCK || cmd == fsr_pkg::CMD_OTP_PROG);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			read_mode <= fsr_pkg::FSR_ARRAY;
		end else if (wr_done) begin
			if (operand_due) begin
				read_mode <= fsr_pkg::FSR_STATUS;
			end else begin
				unique case (cmd)
					fsr_pkg::CMD_READ_ARRAY: read_mode <= fsr_pkg::FSR_ARRAY;
					fsr_pkg::CMD_READ_STAT:  read_mode <= fsr_pkg::FSR_STATUS;
					fsr_pkg::CMD_READ_ID:    read_mode <= fsr_pkg::FSR_IDENT;
					fsr_pkg::CMD_QUERY:      read_mode <= fsr_pkg::FSR_QUERY;
					default:                 read_mode <= read_mode;
				endcase
			end
		end
	end

	// ************************************************************
	// Status word
	// ************************************************************
	logic efail;
	logic pfail;
	logic lowv;
	logic locka;
	logic seq_hold;

	// Sticky bits: set wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			efail <= 1'b0;
			pfail <= 1'b0;
			lowv  <= 1'b0;
			locka <= 1'b0;
		end else begin
			efail <= engine.erase_fail || engine.seq_error || (efail && !clr_stat);
			pfail <= engine.prog_fail || engine.seq_error || (pfail && !clr_stat);
			lowv  <= engine.low_volt || (lowv && !clr_stat);
			locka <= engine.lock_abort || (locka && !clr_stat);
		end
	end

	// A sequence error reports ready even if the engine is mid-suspend
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			seq_hold <= 1'b0;
		end else begin
			seq_hold <= engine.seq_error || (seq_hold && !clr_stat);
		end
	end

	logic [7:0] live_status;
	always_comb begin
		live_status                   = 8'h00;
		live_status[fsr_pkg::SB_READY] = engine.ready || seq_hold;
		live_status[fsr_pkg::SB_ESUSP] = engine.erase_susp;
		live_status[fsr_pkg::SB_EFAIL] = efail;
		live_status[fsr_pkg::SB_PFAIL] = pfail;
		live_status[fsr_pkg::SB_LOWV]  = lowv;
		live_status[fsr_pkg::SB_PSUSP] = engine.prog_susp;
		live_status[fsr_pkg::SB_LOCKA] = locka;
		live_status[fsr_pkg::SB_FBUSY] = engine.factory_busy;
	end

	// Latched copy is what the bus sees; it only moves on an access start
	logic async_armed;
	logic refresh;
	assign refresh = sync_burst_mode ? (ce_fall || adv_fall)
		: ((ce_fall || oe_fall) && async_armed);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			async_armed <= 1'b1;
		end else if (chip_enable_n && output_enable_n) begin
			async_armed <= 1'b1;
		end else if (ce_fall || oe_fall) begin
			async_armed <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			status_word <= fsr_pkg::STATUS_RESET;
		end else if (refresh) begin
			status_word <= live_status;
		end
	end

	// ************************************************************
	// Identifier and query storage
	// ************************************************************
	logic [15:0] prot_mem [fsr_pkg::PROT_WORDS];
	logic [15:0] cfi_mem  [fsr_pkg::CFI_WORDS];
	always_ff @(posedge sys_clk) begin
		if (prot_wr && prot_wr_idx < 8'(fsr_pkg::PROT_WORDS)) begin
			prot_mem[prot_wr_idx] <= mem_wr_data;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (cfi_wr) begin
			cfi_mem[cfi_wr_idx] <= mem_wr_data;
		end
	end

	// Offset 0x80..0x109 maps to prot_mem index 0..137 minus lock words
	function automatic logic [15:0] ident_word(input logic [8:0] ofs);
		logic [8:0] idx;
		idx = ofs - fsr_pkg::OFS_OTPLK0;
		if (ofs == fsr_pkg::OFS_MAKER) begin
			ident_word = fsr_pkg::MAKER_CODE;
		end else if (ofs == fsr_pkg::OFS_PART) begin
			ident_word = fsr_pkg::PART_CODE;
		end else if (ofs == fsr_pkg::OFS_LOCK) begin
			ident_word = 16'(block_lock_state);
		end else if (ofs == fsr_pkg::OFS_RCFG) begin
			ident_word = read_configuration_word;
		end else if (ofs == fsr_pkg::OFS_OTPLK0) begin
			ident_word = otp_lock_word_0;
		end else if (ofs == fsr_pkg::OFS_OTPLK1) begin
			ident_word = otp_lock_word_1;
		end else if (ofs >= fsr_pkg::OFS_PROT0 && ofs <= fsr_pkg::OFS_PROTN) begin
			ident_word = prot_mem[idx[7:0]];
		end else begin
			ident_word = 16'h0000;
		end
	endfunction

	// ************************************************************
	// Read data path
	// ************************************************************
	// Block offset 2 is decoded in the low bits, so any block answers
	logic [15:0] next_data_out;
	always_comb begin
		next_data_out = array_data;
		unique case (read_mode)
			fsr_pkg::FSR_ARRAY:  next_data_out = array_data;
			fsr_pkg::FSR_STATUS: next_data_out = {fsr_pkg::STATUS_HIGH, status_word};
			fsr_pkg::FSR_IDENT:  next_data_out = ident_word(address[8:0]);
			fsr_pkg::FSR_QUERY:  next_data_out = cfi_mem[address[5:0]];
		endcase
	end

	// Non-array words hold still through a burst; address or a new access start (status refresh) moves them
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_out <= 16'h0000;
		end else begin
			data_out <= next_data_out;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= !chip_enable_n && !output_enable_n && write_enable_n;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_status_cmd_mode: assert property (wr_done && !operand_due && cmd == fsr_pkg::CMD_READ_STAT
		|=> read_mode == fsr_pkg::FSR_STATUS) else $error("read status command ignored");
	a_setup_to_status: assert property (wr_done && operand_due
		|=> read_mode == fsr_pkg::FSR_STATUS) else $error("no status after sequence");
	a_status_high_zero: assert property (read_mode == fsr_pkg::FSR_STATUS && $stable(read_mode)
		&& $stable(status_word) |=> data_out[15:8] == 8'h00 && data_out[7:0] == $past(status_word))
		else $error("status word misplaced");
	a_async_latch_only: assert property (!sync_burst_mode && !ce_fall && !oe_fall
		|=> $stable(status_word)) else $error("status moved without edge");
	a_sync_refresh: assert property (sync_burst_mode && (ce_fall || adv_fall)
		|=> status_word == $past(live_status)) else $error("burst status not refreshed");
	a_ready_bit: assert property (refresh && !seq_hold
		|=> status_word[fsr_pkg::SB_READY] == $past(engine.ready)) else $error("ready bit wrong");
	a_seq_error_bits: assert property (engine.seq_error
		|=> live_status[7] && live_status[5] && live_status[4]) else $error("seq error bits");
	a_sticky_hold: assert property (efail && !clr_stat |=> efail [*1]) else $error("sticky bit lost");
	a_clear_status: assert property (clr_stat && !engine.erase_fail && !engine.seq_error
		|=> !efail) else $error("clear not applied");
	a_ident_codes: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_MAKER
		&& $stable(read_mode) |=> data_out == fsr_pkg::MAKER_CODE) else $error("maker code");
	a_lock_word: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_LOCK
		|=> data_out == 16'($past(block_lock_state))) else $error("lock word");


	// ************************************************************
	// Status bit checks
	// ************************************************************
	// Sticky bits must survive anything but a clear or reset
	a_pfail_sticky: assert property (pfail && !clr_stat |=> pfail)
		else $error("program fail bit lost");
	a_lowv_sticky: assert property (lowv && !clr_stat |=> lowv)
		else $error("low supply bit lost");
	a_locka_sticky: assert property (locka && !clr_stat |=> locka)
		else $error("lock abort bit lost");
	a_efail_set: assert property (engine.erase_fail |=> efail)
		else $error("erase fail not set");
	a_pfail_set: assert property (engine.prog_fail |=> pfail)
		else $error("program fail not set");
	a_lowv_set: assert property (engine.low_volt |=> lowv)
		else $error("low supply not set");
	// A set pulse that meets a clear must still be seen by the host
	a_set_beats_clear: assert property (engine.lock_abort && clr_stat |=> locka)
		else $error("clear beat a set");
	a_clear_lowv: assert property (clr_stat && !engine.low_volt |=> !lowv)
		else $error("low supply not cleared");
	a_clear_locka: assert property (clr_stat && !engine.lock_abort |=> !locka)
		else $error("lock abort not cleared");
	a_seq_ready: assert property (seq_hold |-> live_status[fsr_pkg::SB_READY])
		else $error("sequence error not ready");
	a_esusp_bit: assert property (refresh |=> status_word[fsr_pkg::SB_ESUSP] == $past(engine.erase_susp))
		else $error("erase suspend bit wrong");
	a_psusp_bit: assert property (refresh |=> status_word[fsr_pkg::SB_PSUSP] == $past(engine.prog_susp))
		else $error("program suspend bit wrong");
	a_fbusy_bit: assert property (refresh |=> status_word[fsr_pkg::SB_FBUSY] == $past(engine.factory_busy))
		else $error("factory busy bit wrong");
	a_high_byte: assert property (read_mode == fsr_pkg::FSR_STATUS |=> data_out[15:8] == 8'h00)
		else $error("status high byte not zero");

	// ************************************************************
	// Identifier and mode checks
	// ************************************************************
	a_part_code: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_PART
		|=> data_out == fsr_pkg::PART_CODE) else $error("part code");
	a_rcfg_word: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_RCFG
		|=> data_out == $past(read_configuration_word)) else $error("configuration word");
	a_otp_lock0: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_OTPLK0
		|=> data_out == $past(otp_lock_word_0)) else $error("lock word 0");
	a_otp_lock1: assert property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_OTPLK1
		|=> data_out == $past(otp_lock_word_1)) else $error("lock word 1");
	a_query_mode: assert property (wr_done && !operand_due && cmd == fsr_pkg::CMD_QUERY
		|=> read_mode == fsr_pkg::FSR_QUERY) else $error("query command ignored");
	a_array_mode: assert property (wr_done && !operand_due && cmd == fsr_pkg::CMD_READ_ARRAY
		|=> read_mode == fsr_pkg::FSR_ARRAY) else $error("read array ignored");
	// Only a write strobe may move the read state
	a_mode_hold: assert property (!wr_done |=> $stable(read_mode))
		else $error("read state moved without write");

	c_status_read: cover property (read_mode == fsr_pkg::FSR_STATUS && data_oe);
	c_burst_repeat: cover property (sync_burst_mode && data_oe && read_mode == fsr_pkg::FSR_STATUS [*4]);
	c_async_refresh: cover property (!sync_burst_mode && refresh ##[1:20] refresh);
	c_seq_error_clear: cover property (engine.seq_error ##[1:20] clr_stat);
	c_ident_prot: cover property (read_mode == fsr_pkg::FSR_IDENT && address[8:0] == fsr_pkg::OFS_PROTN);

endmodule : fsr_read_states
`default_nettype wire

// *** shared/fsr_pkg.sv ***
`default_nettype none
package fsr_pkg;
	// Bus commands (low data byte of a write)
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STAT  = 8'h70;
	localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
	localparam logic [7:0] CMD_READ_ID    = 8'h90;
	localparam logic [7:0] CMD_QUERY      = 8'h98;
	localparam logic [7:0] CMD_PROG_A     = 8'h40;
	localparam logic [7:0] CMD_PROG_B     = 8'h10;
	localparam logic [7:0] CMD_ERASE      = 8'h20;
	localparam logic [7:0] CMD_LOCK       = 8'h60;
	localparam logic [7:0] CMD_OTP_PROG   = 8'hC0;
	// Identifier space offsets
	localparam logic [8:0] OFS_MAKER  = 9'h000;
	localparam logic [8:0] OFS_PART   = 9'h001;
	localparam logic [8:0] OFS_LOCK   = 9'h002;
	localparam logic [8:0] OFS_RCFG   = 9'h005;
	localparam logic [8:0] OFS_OTPLK0 = 9'h080;
	localparam logic [8:0] OFS_PROT0  = 9'h081;
	localparam logic [8:0] OFS_OTPLK1 = 9'h089;
	localparam logic [8:0] OFS_PROTN  = 9'h109;
	localparam int         PROT_WORDS = 138;
	localparam int         CFI_WORDS  = 64;
	// Status word bit positions
	localparam int SB_READY = 7;
	localparam int SB_ESUSP = 6;
	localparam int SB_EFAIL = 5;
	localparam int SB_PFAIL = 4;
	localparam int SB_LOWV  = 3;
	localparam int SB_PSUSP = 2;
	localparam int SB_LOCKA = 1;
	localparam int SB_FBUSY = 0;
	localparam logic [7:0]  STATUS_RESET = 8'h80;
	localparam logic [7:0]  STATUS_HIGH  = 8'h00;
	localparam logic [15:0] MAKER_CODE   = 16'h00A5; // Arbitrary value
	localparam logic [15:0] PART_CODE    = 16'h5A01; // Arbitrary value

	typedef enum logic [1:0] {FSR_ARRAY, FSR_STATUS, FSR_IDENT, FSR_QUERY} fsr_mode_t;

	// Write engine report: levels it drives, and one-cycle set pulses
	typedef struct packed {
		logic ready;
		logic erase_susp;
		logic prog_susp;
		logic factory_busy;
		logic erase_fail;
		logic prog_fail;
		logic low_volt;
		logic lock_abort;
		logic seq_error;
	} fsr_engine_t;
endpackage : fsr_pkg
`default_nettype wire

// *** tb/fsr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Flash bus
	output logic             chip_enable_n,
	output logic             output_enable_n,
	output logic             write_enable_n,
	output logic             address_valid_n,
	output logic [15:0]      address,
	output logic [15:0]      data_in,
	input  wire logic [15:0] data_out
);
	logic [15:0] rd_data;
	event        got;
	initial begin
		{chip_enable_n, output_enable_n, write_enable_n, address_valid_n} = 4'hF;
		address = 16'h0000;
		data_in = 16'hFFFF;
	end
	// ******************************
	// Bus cycles
	// ******************************
	task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk) #1;
		address = a;
		data_in = d;
		chip_enable_n = 1'b0;
		write_enable_n = 1'b0;
		@(posedge sys_clk) #1;
		write_enable_n = 1'b1;
		@(posedge sys_clk) #1;
		chip_enable_n = 1'b1;
		// Released lines must not look held
		data_in = ~d;
	endtask : bus_write
	task automatic bus_read(input logic [15:0] a, input int n);
		@(posedge sys_clk) #1;
		address = a;
		chip_enable_n = 1'b0;
		output_enable_n = 1'b0;
		address_valid_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk) #1;
			rd_data = data_out;
			-> got;
		end
		{chip_enable_n, output_enable_n, address_valid_n} = 3'h7;
	endtask : bus_read
endmodule : fsr_host_model
`default_nettype wire

// *** tb/test_flash_status_and_id_read.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_status_and_id_read;
	logic                 sys_clk = 1'b0, rst_b = 1'b0;
	logic                 chip_enable_n, output_enable_n, write_enable_n, address_valid_n;
	logic                 data_oe, sync_burst_mode, prot_wr, cfi_wr;
	logic [15:0]          address, data_in, data_out, rcfg, array_data, otp0, otp1, mem_wr_data;
	logic [1:0]           lock;
	logic [7:0]           prot_wr_idx, status_word;
	logic [5:0]           cfi_wr_idx;
	fsr_pkg::fsr_engine_t eng;
	fsr_pkg::fsr_mode_t   read_mode;
	logic [15:0]          expq[$], id_exp[6], pw[7];
	int                   miscompares = 0, n_compared = 0;
	logic [7:0]           sticky[5] = '{8'hB0, 8'h82, 8'h88, 8'h90, 8'hA0};
	logic [8:0]           lvl[4] = '{9'h000, 9'h180, 9'h140, 9'h020};
	logic [7:0]           lvl_exp[4] = '{8'h00, 8'hC0, 8'h84, 8'h01};
	logic [8:0]           id_ofs[6] = '{9'h000, 9'h001, 9'h002, 9'h005, 9'h080, 9'h089};
	logic [8:0]           pr_ofs[7] = '{9'h081, 9'h084, 9'h085, 9'h088, 9'h08A, 9'h108, 9'h109};
	logic [7:0]           setup[5];

	always #5 sys_clk = ~sys_clk;

	fsr_read_states dut (.sys_clk, .rst_b, .chip_enable_n, .output_enable_n, .write_enable_n,
		.address_valid_n, .address, .data_in, .data_out, .data_oe, .sync_burst_mode,
		.read_configuration_word(rcfg), .array_data, .block_lock_state(lock), .otp_lock_word_0(otp0),
		.otp_lock_word_1(otp1), .engine(eng), .prot_wr, .prot_wr_idx, .cfi_wr, .cfi_wr_idx,
		.mem_wr_data, .read_mode, .status_word);
	fsr_host_model host (.sys_clk, .chip_enable_n, .output_enable_n, .write_enable_n,
		.address_valid_n, .address, .data_in, .data_out);

	// ******************************
	// Checking
	// ******************************
	always @(host.got) begin
		logic [15:0] want;
		want = expq.pop_front();
		n_compared++;
		if (host.rd_data !== want) begin
			miscompares++;
			$display("MISMATCH data_out expected %h seen %h", want, host.rd_data);
		end
		n_compared++;
		if (data_oe !== 1'b1) begin
			miscompares++;
			$display("MISMATCH data_oe expected 1 seen %b", data_oe);
		end
	end
	function automatic logic [15:0] ra();
		return 16'($urandom);
	endfunction : ra
	task automatic cmd(input logic [7:0] c);
		host.bus_write(ra(), {8'h00, c});
	endtask : cmd
	task automatic rd(input logic [15:0] a, input logic [15:0] v);
		expq.push_back(v);
		host.bus_read(a, 1);
	endtask : rd
	task automatic load(input logic cfi, input logic [7:0] idx, input logic [15:0] d);
		@(posedge sys_clk) #1;
		prot_wr = ~cfi;
		cfi_wr = cfi;
		prot_wr_idx = idx;
		cfi_wr_idx = idx[5:0];
		mem_wr_data = d;
		@(posedge sys_clk) #1;
		prot_wr = 1'b0;
		cfi_wr = 1'b0;
	endtask : load
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// Whole run needs well under 20k cycles
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end

	// ******************************
	// Scenarios
	// ******************************
	initial begin
		void'($urandom(32'hEB60CCC7));
		{sync_burst_mode, prot_wr, cfi_wr, prot_wr_idx, cfi_wr_idx, mem_wr_data} = '0;
		{rcfg, array_data, otp0, otp1} = {$urandom, $urandom};
		lock = 2'($urandom);
		eng = 9'h100;
		setup = '{fsr_pkg::CMD_PROG_A, fsr_pkg::CMD_PROG_B, fsr_pkg::CMD_ERASE, fsr_pkg::CMD_LOCK,
			fsr_pkg::CMD_OTP_PROG};
		id_exp = '{fsr_pkg::MAKER_CODE, fsr_pkg::PART_CODE, {14'h0000, lock}, rcfg, otp0, otp1};
		repeat (20) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		rd(ra(), array_data);
		cmd(fsr_pkg::CMD_READ_STAT);
		rd(ra(), 16'h0080);
		for (int k = 0; k < 4; k++) begin
			eng = lvl[k];
			rd(ra(), {8'h00, lvl_exp[k]});
		end
		eng = 9'h100;
		$display("level flags done");
		for (int k = 0; k < 5; k++) begin
			cmd(fsr_pkg::CMD_CLR_STAT);
			cmd(fsr_pkg::CMD_READ_STAT);
			rd(ra(), 16'h0080);
			@(posedge sys_clk) #1;
			eng[k] = 1'b1;
			@(posedge sys_clk) #1;
			eng[k] = 1'b0;
			rd(ra(), {8'h00, sticky[k]});
			rd(ra(), {8'h00, sticky[k]});
		end
		rst_b = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		cmd(fsr_pkg::CMD_READ_STAT);
		rd(ra(), 16'h0080);
		$display("sticky flags done");
		for (int k = 0; k < 5; k++) begin
			cmd(fsr_pkg::CMD_READ_ARRAY);
			rd(ra(), array_data);
			cmd(setup[k]);
			host.bus_write(ra(), 16'h00D0);
			rd(ra(), 16'h0080);
		end
		$display("sequences done");
		for (int k = 0; k < 7; k++) begin
			pw[k] = 16'($urandom);
			load(1'b0, 8'(pr_ofs[k] - 9'h080), pw[k]);
		end
		cmd(fsr_pkg::CMD_READ_ID);
		for (int k = 0; k < 6; k++)
			rd({7'($urandom), id_ofs[k]}, id_exp[k]);
		for (int k = 0; k < 7; k++)
			rd({7'($urandom), pr_ofs[k]}, pw[k]);
		for (int k = 0; k < 2; k++)
			load(1'b1, 8'(k * 47), pw[k]);
		cmd(fsr_pkg::CMD_QUERY);
		for (int k = 0; k < 2; k++)
			rd({10'($urandom), 6'(k * 47)}, pw[k]);
		$display("identifier and query done");
		cmd(fsr_pkg::CMD_READ_STAT);
		for (int m = 0; m < 2; m++) begin
			sync_burst_mode = m[0];
			repeat (6) expq.push_back(16'h0080);
			fork
				host.bus_read(16'h0000, 6);
				begin
					repeat (6) @(posedge sys_clk);
					#1 eng = 9'h180;
				end
			join
			rd(ra(), 16'h00C0);
			eng = 9'h100;
		end
		$display("burst refresh done");
		wrap_up();
	end
endmodule : test_flash_status_and_id_read
`default_nettype wire
